// *** inc/cslu_pkg.sv ***
// ----------------------------------------------------------------------
// console serial-line unit constants
// ----------------------------------------------------------------------
package cslu_pkg;

  // processor register numbers
  localparam logic [7:0] REG_RX_CONTROL = 8'h20;
  localparam logic [7:0] REG_RX_BUFFER  = 8'h21;
  localparam logic [7:0] REG_TX_CONTROL = 8'h22;
  localparam logic [7:0] REG_TX_BUFFER  = 8'h23;

  // receive control field positions
  localparam int RXC_IE_BIT   = 6;
  localparam int RXC_DONE_BIT = 7;
  localparam int RXC_LP_BIT   = 12;

  // receive buffer field positions
  localparam int RXB_DATA_LSB = 0;
  localparam int RXB_BRK_BIT  = 14;
  localparam int RXB_ERR_BIT  = 15;

  // transmit control field positions
  localparam int TXC_IE_BIT    = 6;
  localparam int TXC_READY_BIT = 7;
  localparam int TXC_BRE_BIT   = 8;
  localparam int TXC_RATE_LSB  = 9;
  localparam int TXC_BRK_BIT   = 12;
  localparam int TXC_LP_BIT    = 13;

  // transmit buffer fields
  localparam int TXB_DATA_LSB = 0;
  localparam int TXB_TAG_LSB  = 8;
  localparam logic [3:0] TAG_DATA = 4'h0;
  localparam logic [3:0] TAG_CMD  = 4'hF;

  // console command codes
  localparam logic [7:0] CMD_BOOT     = 8'h02;
  localparam logic [7:0] CMD_WARM_CLR = 8'h03;
  localparam logic [7:0] CMD_COLD_CLR = 8'h04;

  // reset values and request level
  localparam logic [2:0] RATE_RESET = 3'h6;
  localparam logic [4:0] IRQ_LEVEL  = 5'h14;

  // bit timing: 16 ticks per bit, sample at tick 7 of start bit
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned BASE_BAUD  = 150;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned BASE_DIV   = CLK_HZ / (BASE_BAUD * OVERSAMPLE);
  localparam int          DIV_W      = 17;
  localparam logic [3:0]  TICK_LAST  = 4'hF;
  localparam logic [3:0]  TICK_MID   = 4'h7;
  localparam logic [2:0]  BIT_LAST   = 3'h7;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_STOP
  } cslu_ser_st_t;

endpackage

// *** inc/cslu_baud_if.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// baud selection and oversample tick
// ----------------------------------------------------------------------
interface cslu_baud_if;
  logic [2:0] rate_sel;
  logic       tick;
  modport gen  (input rate_sel, output tick);
  modport user (output rate_sel, input tick);
endinterface

// *** hw/cslu_baud_gen.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// oversample tick divider, rate doubles per select step
// ----------------------------------------------------------------------
module cslu_baud_gen #(
  parameter int unsigned BASE_DIV = cslu_pkg::BASE_DIV
) (
  input  wire logic  ref_clk_in,
  input  wire logic  sys_rst_in,
  input  wire logic  ce_in,
  cslu_baud_if.gen   baud
);
  localparam int W = cslu_pkg::DIV_W;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } cslu_baud_state_t;

  cslu_baud_state_t s_r;
  cslu_baud_state_t s_nxt;
  logic [W-1:0]     limit;

  // each select step halves the divisor, so rates double per step
  assign limit = W'((BASE_DIV >> baud.rate_sel) - 1);

  // down counter, tick on wrap
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == '0) begin
      s_nxt.cnt  = limit;
      s_nxt.tick = 1'b1;
    end else if (s_r.cnt > limit) begin
      s_nxt.cnt = limit; // rate raised: cut the wait short
    end else begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_r <= '0;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign baud.tick = s_r.tick;
endmodule // cslu_baud_gen

// *** hw/cslu_console.sv ***
`timescale 1ns/10ps
// Function
// - receive done with enable requests level-20 interrupt
// - receive loopback bit selects internal bus
// - overrun or framing error sets error flag
// - break sets break flag, error stays clear
// - reading receive buffer clears done
// - ready shows transmitter idle
// - ready with enable requests level-20 interrupt
// - data buffer write clears ready until sent
// - rate-load bit loads rate field
// - rate field doubles from 150 to 19200
// - break bit holds line in continuous break
// - transmit loopback routes to bus, line idles
// - tag field separates data from commands
// - command codes boot, clear warm, clear cold
module cslu_console #(
  parameter int unsigned BASE_DIV = cslu_pkg::BASE_DIV
) (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  input  wire logic        move_to_processor_register_stb_in,
  input  wire logic        move_from_processor_register_stb_in,
  input  wire logic [7:0]  reg_num_in,
  input  wire logic [31:0] wr_data_in,
  output logic      [31:0] rd_data_out,
  output logic             rd_valid_out,
  input  wire logic        ser_rx_in,
  output logic             ser_tx_out,
  input  wire logic        loop_bus_in,
  output logic             loop_bus_out,
  output logic             rx_irq_out,
  output logic             tx_irq_out,
  output logic      [4:0]  irq_level_out,
  output logic             boot_req_out,
  output logic             warm_clr_out,
  output logic             cold_clr_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                  rx_ie;
    logic                  rx_done;
    logic                  rx_lp;
    logic [7:0]            rx_data;
    logic                  rx_err;
    logic                  rx_brk;
    cslu_pkg::cslu_ser_st_t rx_st;
    logic [3:0]            rx_tk;
    logic [2:0]            rx_bit;
    logic [7:0]            rx_sh;
    logic                  tx_ie;
    logic                  tx_brk;
    logic                  tx_lp;
    logic [2:0]            rate;
    cslu_pkg::cslu_ser_st_t tx_st;
    logic [3:0]            tx_tk;
    logic [2:0]            tx_bit;
    logic [7:0]            tx_sh;
    logic                  tx_line;
    logic [31:0]           rd_data;
    logic                  rd_valid;
    logic                  boot;
    logic                  warm_clr;
    logic                  cold_clr;
  } cslu_state_t;

  cslu_state_t s_r;
  cslu_state_t s_nxt;

  cslu_baud_if baud ();

  logic       tick;
  logic       frame_line;
  logic       rx_src;
  logic       wr_rxc;
  logic       wr_txc;
  logic       wr_txb;
  logic       rd_rxb;
  logic [3:0] tag;
  logic [7:0] wdata;
  logic       tx_ready;
  logic       stop_low;
  logic       brk_frame;

  // ----------------------------------------------------------------------
  // baud divider
  // ----------------------------------------------------------------------
  // one shared divider, so a rate load retimes both directions at once
  assign baud.rate_sel = s_r.rate;
  assign tick          = baud.tick;

  cslu_baud_gen #(
    .BASE_DIV (BASE_DIV)
  ) u_baud (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .baud       (baud)
  );

  // ----------------------------------------------------------------------
  // line routing
  // ----------------------------------------------------------------------
  // break overrides framing, so software times the break itself
  assign frame_line   = s_r.tx_brk ? 1'b0 : s_r.tx_line;
  assign ser_tx_out   = s_r.tx_lp ? 1'b1 : frame_line;
  assign loop_bus_out = s_r.tx_lp ? frame_line : 1'b1;
  // other units drive the bus idle-high; the receiver takes the and of both drivers
  assign rx_src = s_r.rx_lp ? (loop_bus_in & loop_bus_out) : ser_rx_in;

  // ----------------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------------
  assign wr_rxc = move_to_processor_register_stb_in && (reg_num_in == cslu_pkg::REG_RX_CONTROL);
  assign wr_txc = move_to_processor_register_stb_in && (reg_num_in == cslu_pkg::REG_TX_CONTROL);
  assign wr_txb = move_to_processor_register_stb_in && (reg_num_in == cslu_pkg::REG_TX_BUFFER);
  assign rd_rxb = move_from_processor_register_stb_in && (reg_num_in == cslu_pkg::REG_RX_BUFFER);
  assign tag    = wr_data_in[cslu_pkg::TXB_TAG_LSB +: 4];
  assign wdata  = wr_data_in[cslu_pkg::TXB_DATA_LSB +: 8];

  // ----------------------------------------------------------------------
  // derived status
  // ----------------------------------------------------------------------
  // ready is the idle state itself, so it cannot disagree with the line
  assign tx_ready  = (s_r.tx_st == cslu_pkg::SER_IDLE);
  // stop level and break shape, only meaningful at the stop sample
  assign stop_low  = !rx_src;
  assign brk_frame = (s_r.rx_sh == '0) && stop_low;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.boot     = 1'b0;
    s_nxt.warm_clr = 1'b0;
    s_nxt.cold_clr = 1'b0;

    // register reads, answered one cycle later; unknown numbers read zero
    if (move_from_processor_register_stb_in) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_data  = '0;
      case (reg_num_in)
        cslu_pkg::REG_RX_CONTROL: begin
          s_nxt.rd_data[cslu_pkg::RXC_IE_BIT]   = s_r.rx_ie;
          s_nxt.rd_data[cslu_pkg::RXC_DONE_BIT] = s_r.rx_done;
          s_nxt.rd_data[cslu_pkg::RXC_LP_BIT]   = s_r.rx_lp;
        end
        cslu_pkg::REG_RX_BUFFER: begin
          s_nxt.rd_data[cslu_pkg::RXB_DATA_LSB +: 8] = s_r.rx_data;
          s_nxt.rd_data[cslu_pkg::RXB_BRK_BIT]       = s_r.rx_brk;
          s_nxt.rd_data[cslu_pkg::RXB_ERR_BIT]       = s_r.rx_err;
        end
        cslu_pkg::REG_TX_CONTROL: begin
          // rate-load bit is write only and reads back as zero
          s_nxt.rd_data[cslu_pkg::TXC_IE_BIT]         = s_r.tx_ie;
          s_nxt.rd_data[cslu_pkg::TXC_READY_BIT]      = tx_ready;
          s_nxt.rd_data[cslu_pkg::TXC_RATE_LSB +: 3]  = s_r.rate;
          s_nxt.rd_data[cslu_pkg::TXC_BRK_BIT]        = s_r.tx_brk;
          s_nxt.rd_data[cslu_pkg::TXC_LP_BIT]         = s_r.tx_lp;
        end
        default: begin
          s_nxt.rd_data = '0;
        end
      endcase
    end

    // control writes
    // rate moves only with the load bit, other fields can be set alone
    if (wr_rxc) begin
      s_nxt.rx_ie = wr_data_in[cslu_pkg::RXC_IE_BIT];
      s_nxt.rx_lp = wr_data_in[cslu_pkg::RXC_LP_BIT];
    end
    if (wr_txc) begin
      s_nxt.tx_ie  = wr_data_in[cslu_pkg::TXC_IE_BIT];
      s_nxt.tx_brk = wr_data_in[cslu_pkg::TXC_BRK_BIT];
      s_nxt.tx_lp  = wr_data_in[cslu_pkg::TXC_LP_BIT];
      if (wr_data_in[cslu_pkg::TXC_BRE_BIT]) begin
        s_nxt.rate = wr_data_in[cslu_pkg::TXC_RATE_LSB +: 3];
      end
    end

    // reading the buffer clears done; a frame ending now sets it again
    if (rd_rxb) begin
      s_nxt.rx_done = 1'b0;
    end

    // transmit buffer write: commands are decoded, not sent
    // only the three known codes act; any other command is ignored
    if (wr_txb && (tag == cslu_pkg::TAG_CMD)) begin
      case (wdata)
        cslu_pkg::CMD_BOOT:     s_nxt.boot     = 1'b1;
        cslu_pkg::CMD_WARM_CLR: s_nxt.warm_clr = 1'b1;
        cslu_pkg::CMD_COLD_CLR: s_nxt.cold_clr = 1'b1;
        default: begin
          s_nxt.boot = 1'b0;
        end
      endcase
    end

    // transmitter; a data write while busy is dropped
    case (s_r.tx_st)
      cslu_pkg::SER_IDLE: begin
        // mark level while nothing is queued
        s_nxt.tx_line = 1'b1;
        if (wr_txb && (tag != cslu_pkg::TAG_CMD)) begin
          s_nxt.tx_sh   = wdata;
          s_nxt.tx_st   = cslu_pkg::SER_START;
          s_nxt.tx_tk   = '0;
          s_nxt.tx_line = 1'b0;
        end
      end
      cslu_pkg::SER_START: begin
        // first tick may land early, so the start bit can be one tick short
        if (tick) begin
          s_nxt.tx_tk = s_r.tx_tk + 4'h1;
          if (s_r.tx_tk == cslu_pkg::TICK_LAST) begin
            s_nxt.tx_st   = cslu_pkg::SER_DATA;
            s_nxt.tx_bit  = '0;
            s_nxt.tx_line = s_r.tx_sh[0];
          end
        end
      end
      cslu_pkg::SER_DATA: begin
        // lsb first; the next bit is taken before the shift lands
        if (tick) begin
          s_nxt.tx_tk = s_r.tx_tk + 4'h1;
          if (s_r.tx_tk == cslu_pkg::TICK_LAST) begin
            s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
            if (s_r.tx_bit == cslu_pkg::BIT_LAST) begin
              s_nxt.tx_st   = cslu_pkg::SER_STOP;
              s_nxt.tx_line = 1'b1;
            end else begin
              s_nxt.tx_bit  = s_r.tx_bit + 3'h1;
              s_nxt.tx_line = s_r.tx_sh[1];
            end
          end
        end
      end
      cslu_pkg::SER_STOP: begin
        // ready only returns once the stop bit is fully out
        if (tick) begin
          s_nxt.tx_tk = s_r.tx_tk + 4'h1;
          if (s_r.tx_tk == cslu_pkg::TICK_LAST) begin
            s_nxt.tx_st = cslu_pkg::SER_IDLE;
          end
        end
      end
      default: begin
        s_nxt.tx_st = cslu_pkg::SER_IDLE;
      end
    endcase

    // receiver, 16x oversampled, one sample at bit centre
    case (s_r.rx_st)
      cslu_pkg::SER_IDLE: begin
        // a low level seen on a tick may open a frame
        if (tick && !rx_src) begin
          s_nxt.rx_st = cslu_pkg::SER_START;
          s_nxt.rx_tk = '0;
        end
      end
      cslu_pkg::SER_START: begin
        if (tick) begin
          s_nxt.rx_tk = s_r.rx_tk + 4'h1;
          if (s_r.rx_tk == cslu_pkg::TICK_MID) begin
            // a glitch shorter than half a bit is not a start bit
            s_nxt.rx_st  = rx_src ? cslu_pkg::SER_IDLE : cslu_pkg::SER_DATA;
            s_nxt.rx_tk  = '0;
            s_nxt.rx_bit = '0;
          end
        end
      end
      cslu_pkg::SER_DATA: begin
        // sample lands mid-bit, a full bit after the confirmed centre
        if (tick) begin
          s_nxt.rx_tk = s_r.rx_tk + 4'h1;
          if (s_r.rx_tk == cslu_pkg::TICK_LAST) begin
            s_nxt.rx_sh = {rx_src, s_r.rx_sh[7:1]};
            if (s_r.rx_bit == cslu_pkg::BIT_LAST) begin
              s_nxt.rx_st = cslu_pkg::SER_STOP;
            end else begin
              s_nxt.rx_bit = s_r.rx_bit + 3'h1;
            end
          end
        end
      end
      cslu_pkg::SER_STOP: begin
        if (tick) begin
          s_nxt.rx_tk = s_r.rx_tk + 4'h1;
          if (s_r.rx_tk == cslu_pkg::TICK_LAST) begin
            s_nxt.rx_st   = cslu_pkg::SER_IDLE;
            s_nxt.rx_data = s_r.rx_sh;
            // all-zero frame with low stop is a break, not an error
            s_nxt.rx_brk  = brk_frame;
            s_nxt.rx_err  = !brk_frame && (stop_low || s_r.rx_done);
            s_nxt.rx_done = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.rx_st = cslu_pkg::SER_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // reset leaves both engines idle with the line at mark
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_r         <= '0;
      s_r.rx_st   <= cslu_pkg::SER_IDLE;
      s_r.tx_st   <= cslu_pkg::SER_IDLE;
      s_r.tx_line <= 1'b1;
      s_r.rate    <= cslu_pkg::RATE_RESET;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // data outputs come straight from flip-flops
  assign rd_data_out  = s_r.rd_data;
  assign rd_valid_out = s_r.rd_valid;
  assign boot_req_out = s_r.boot;
  assign warm_clr_out = s_r.warm_clr;
  assign cold_clr_out = s_r.cold_clr;

  // level requests, held until the cause or the enable drops
  assign rx_irq_out    = s_r.rx_done && s_r.rx_ie;
  assign tx_irq_out    = tx_ready && s_r.tx_ie;
  assign irq_level_out = (rx_irq_out || tx_irq_out) ? cslu_pkg::IRQ_LEVEL : 5'h00;

endmodule // cslu_console

// *** tb/cslu_console_monitor.sv ***
`timescale 1ns/10ps
// ------
// console unit port checker
// ------
module cslu_monitor (
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        ce_in,
  input wire logic        move_to_processor_register_stb_in,
  input wire logic        move_from_processor_register_stb_in,
  input wire logic [7:0]  reg_num_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        rx_irq_out,
  input wire logic        tx_irq_out,
  input wire logic [4:0]  irq_level_out,
  input wire logic        boot_req_out,
  input wire logic        warm_clr_out,
  input wire logic        cold_clr_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic tx_wr;
  logic is_cmd;
  logic rxb_rd;
  // decoded accesses; ce low means nothing is taken
  assign tx_wr  = ce_in && move_to_processor_register_stb_in && reg_num_in == cslu_pkg::REG_TX_BUFFER;
  assign is_cmd = wr_data_in[11:8] == cslu_pkg::TAG_CMD;
  assign rxb_rd = ce_in && move_from_processor_register_stb_in && reg_num_in == cslu_pkg::REG_RX_BUFFER;

  rx_irq_level_a: assert property (rx_irq_out |-> irq_level_out == 5'h14)
    else $error("receive request at wrong level");
  tx_irq_level_a: assert property (tx_irq_out |-> irq_level_out == 5'h14)
    else $error("transmit request at wrong level");
  irq_idle_a: assert property (!(rx_irq_out || tx_irq_out) |-> irq_level_out == 5'h00)
    else $error("level shown without request");
  ready_clear_a: assert property (tx_wr && !is_cmd && tx_irq_out |=> !tx_irq_out [*8])
    else $error("ready not held clear after data write");
  cmd_boot_a: assert property (tx_wr && wr_data_in[11:0] == 12'hF02 |=> boot_req_out)
    else $error("boot command not decoded");
  cmd_warm_a: assert property (tx_wr && wr_data_in[11:0] == 12'hF03 |=> warm_clr_out)
    else $error("warm clear command not decoded");
  cmd_cold_a: assert property (tx_wr && wr_data_in[11:0] == 12'hF04 |=> cold_clr_out)
    else $error("cold clear command not decoded");
  cmd_keep_ready_a: assert property (tx_wr && is_cmd && tx_irq_out |=> tx_irq_out)
    else $error("command write disturbed ready");
  rx_read_clear_a: assert property (rxb_rd && rx_irq_out |=> !rx_irq_out)
    else $error("buffer read left done set");

  // main scenarios reached
  cover property (tx_wr && is_cmd);
  cover property ($rose(rx_irq_out));
  cover property ($fell(tx_irq_out));
endmodule // cslu_monitor

bind cslu_console cslu_monitor mon (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
  .move_to_processor_register_stb_in(move_to_processor_register_stb_in), .move_from_processor_register_stb_in(move_from_processor_register_stb_in), .reg_num_in(reg_num_in),
  .wr_data_in(wr_data_in), .rx_irq_out(rx_irq_out), .tx_irq_out(tx_irq_out),
  .irq_level_out(irq_level_out), .boot_req_out(boot_req_out),
  .warm_clr_out(warm_clr_out), .cold_clr_out(cold_clr_out));

// *** tb/cslu_term.sv ***
`timescale 1ns/10ps
// ------
// console terminal on the serial line
// ------
module cslu_term (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  int         bit_cyc = 16;
  int         n_got   = 0;
  logic [7:0] got;
  // line rests at mark between frames
  initial line_out = 1'b1;
  // start, eight data lsb first, stop; stop low makes framing errors
  task automatic send_char(input logic [7:0] d, input logic stop);
    int i;
    @(posedge clk_in);
    #1 line_out = 1'b0;
    repeat (bit_cyc) @(posedge clk_in);
    for (i = 0; i < 9; i++) begin
      #1 line_out = (i < 8) ? d[i] : stop;
      repeat (bit_cyc) @(posedge clk_in);
    end
    #1 line_out = 1'b1;
  endtask
  // sample each bit at its centre; bit_cyc tracks the chosen rate
  initial forever begin : rx_loop
    int i;
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge clk_in);
    for (i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk_in);
      got[i] = line_in;
    end
    repeat (bit_cyc) @(posedge clk_in);
    n_got++;
  end
endmodule // cslu_term

// *** tb/test_console_serial_line_unit.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
// ------
// console unit bench
// ------
module test_console_serial_line_unit;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        ce   = 1'b1;
  logic        move_to_processor_register = 1'b0;
  logic        move_from_processor_register = 1'b0;
  logic [7:0]  rnum = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic        lb_in = 1'b1;
  logic [31:0] rdat;
  logic        rvld;
  logic        rx_line;
  logic        tx_line;
  logic        lb_out;
  logic        rirq;
  logic        tirq;
  logic [4:0]  lvl;
  wire  [2:0]  cmd;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          low_cnt      = 0;

  always #2.5 clk = ~clk;
  // cycles the outside line spends low
  always @(posedge clk) if (tx_line === 1'b0) low_cnt++;

  // small divider keeps frames short: rate 7 gives 16-cycle bits
  cslu_console #(.BASE_DIV(128)) dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .ce_in(ce), .move_to_processor_register_stb_in(move_to_processor_register),
    .move_from_processor_register_stb_in(move_from_processor_register), .reg_num_in(rnum), .wr_data_in(wdat), .rd_data_out(rdat),
    .rd_valid_out(rvld), .ser_rx_in(rx_line), .ser_tx_out(tx_line),
    .loop_bus_in(lb_in), .loop_bus_out(lb_out), .rx_irq_out(rirq),
    .tx_irq_out(tirq), .irq_level_out(lvl), .boot_req_out(cmd[2]),
    .warm_clr_out(cmd[1]), .cold_clr_out(cmd[0]));
  cslu_term term (.clk_in(clk), .line_in(tx_line), .line_out(rx_line));

  // ------
  // register access
  // ------
  task automatic wr(input logic [7:0] r, input logic [31:0] d);
    @(posedge clk);
    #1 rnum = r;
    wdat = d;
    move_to_processor_register = 1'b1;
    @(posedge clk);
    #1 move_to_processor_register = 1'b0;
  endtask
  task automatic rd(input logic [7:0] r, input logic [31:0] exp);
    @(posedge clk);
    #1 rnum = r;
    move_from_processor_register = 1'b1;
    @(posedge clk);
    #1 move_from_processor_register = 1'b0;
    `CHK(rvld, 1'b1)
    `CHK(rdat, exp)
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // bounded wait for a sent character or for receive done
  task automatic wait_ev(input bit tx, input int n0);
    int i;
    for (i = 0; i < 2000; i++) begin
      if (tx ? term.n_got != n0 : rirq === 1'b1) return;
      @(posedge clk);
      #1;
    end
    n_mismatch++;
    test_done();
  endtask
  task automatic rx_case(input logic [7:0] d, input logic stop, input logic [31:0] exp);
    term.send_char(d, stop);
    wait_ev(1'b0, 0);
    `CHK(lvl, 5'h14)
    rd(8'h21, exp);
    `CHK(rirq, 1'b0)
  endtask

  // ------
  // scenarios
  // ------
  initial begin : main
    int r;
    int c;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    // reset: ready set, rate 110, line at mark, unmapped reads zero
    rd(8'h22, 32'h0000_0C80);
    rd(8'h20, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    `CHK(tx_line, 1'b1)
    `CHK(lb_out, 1'b1)
    // one character at each of three rates, interrupt enabled
    for (r = 7; r >= 5; r--) begin
      wr(8'h22, 32'h0000_0140 | 32'(r << 9));
      rd(8'h22, 32'h0000_00C0 | 32'(r << 9));
      `CHK(tirq, 1'b1)
      term.bit_cyc = 16 << (7 - r);
      c = term.n_got;
      wr(8'h23, 32'h0000_0050 + 32'(r));
      `CHK(tirq, 1'b0)
      wait_ev(1'b1, c);
      `CHK(term.got, 8'h50 + 8'(r))
      // terminal counts at mid stop; ready only returns after the stop bit
      repeat (term.bit_cyc) @(posedge clk);
      #1;
      `CHK(tirq, 1'b1)
      rd(8'h22, 32'h0000_00C0 | 32'(r << 9));
    end
    // commands pulse once and are not sent; code 5 does nothing
    for (c = 2; c <= 5; c++) begin
      wr(8'h23, 32'h0000_0F00 | 32'(c));
      `CHK(cmd, 3'b100 >> (c - 2))
      `CHK(tirq, 1'b1)
    end
    // break lasts as long as software holds the bit
    wr(8'h22, 32'h0000_1000);
    repeat (40) @(posedge clk);
    `CHK(tx_line, 1'b0)
    wr(8'h22, 32'h0000_0F00);
    @(posedge clk);
    #1;
    `CHK(tx_line, 1'b1)
    term.bit_cyc = 16;
    // receive: clean, framing error, break, overrun
    wr(8'h20, 32'h0000_0040);
    rx_case(8'h3C, 1'b1, 32'h0000_003C);
    rd(8'h20, 32'h0000_0040);
    rx_case(8'h55, 1'b0, 32'h0000_8055);
    rx_case(8'h00, 1'b0, 32'h0000_4000);
    term.send_char(8'h11, 1'b1);
    rx_case(8'h22, 1'b1, 32'h0000_8022);
    // internal loopback, receive and transmit loopback bits both set; line stays at mark
    wr(8'h20, 32'h0000_1040);
    wr(8'h22, 32'h0000_2000);
    low_cnt = 0;
    wr(8'h23, 32'h0000_00A7);
    `CHK(lb_out, 1'b0)
    wait_ev(1'b0, 0);
    `CHK(low_cnt, 0)
    rd(8'h21, 32'h0000_00A7);
    test_done();
  end
endmodule // test_console_serial_line_unit
